// *** core/dspma_cfg.svh ***
`ifndef DSPMA_CFG_SVH
`define DSPMA_CFG_SVH
// ==========================================
// Register map and field layout
`define DSPMA_ADDR_CFG 8'h00
`define DSPMA_ADDR_STAT 8'h04
`define DSPMA_CFG_RST 10'h000
`define DSPMA_CFG_MODE 1:0
`define DSPMA_CFG_WIDTH 3:2
`define DSPMA_CFG_STAGES 5:4
`define DSPMA_CFG_OUTREG 6
`define DSPMA_CFG_CHAIN 7
`define DSPMA_CFG_COEFPAR 8
`define DSPMA_CFG_DLINK 9
`define DSPMA_STAT_ILLEGAL 2
// ==========================================
// Control vector bit positions
`define DSPMA_CTL_LOAD0 0
`define DSPMA_CTL_LOAD1 1
`define DSPMA_CTL_ADDU 2
`define DSPMA_CTL_ADDL 3
`define DSPMA_CTL_SIGNA 4
`define DSPMA_CTL_SIGNB 5
`define DSPMA_CTL_W 6
// ==========================================
// Datapath sizes
`define DSPMA_ACC_W 52
`define DSPMA_DLINK_W 10
`define DSPMA_HRESP_OKAY 1'h0
`endif

// *** core/dspma_pkg.sv ***
// ==========================================
// Operating modes and product widths
package dspma_pkg;
  typedef enum logic [1:0] {
    DSPMA_SIMPLE,
    DSPMA_MAC,
    DSPMA_ADD2,
    DSPMA_ADD4
  } dspma_mode_t;
  typedef enum logic [1:0] {
    DSPMA_W9,
    DSPMA_W18,
    DSPMA_W36,
    DSPMA_WRSV
  } dspma_width_t;
endpackage : dspma_pkg

// *** core/dspma_mult.sv ***
`timescale 1ns/1ps
// ==========================================
// One 18x18 sub-block, split as two 9x9 when asked
module dspma_mult (
  input wire logic clk,
  input wire logic prodRst_n,
  input wire logic enable,
  input wire logic [17:0] opA,
  input wire logic [17:0] opB,
  input wire logic width9,
  input wire logic signA,
  input wire logic signB,
  output logic [35:0] product
);
  logic signed [18:0] fa;
  logic signed [18:0] fb;
  logic signed [37:0] full;
  logic signed [9:0] la;
  logic signed [9:0] lb;
  logic signed [9:0] ha;
  logic signed [9:0] hb;
  logic signed [19:0] lp;
  logic signed [19:0] hp;
  logic [35:0] product_next;

  assign fa = {signA & opA[17], opA};
  assign fb = {signB & opB[17], opB};
  assign la = {signA & opA[8], opA[8:0]};
  assign lb = {signB & opB[8], opB[8:0]};
  assign ha = {signA & opA[17], opA[17:9]};
  assign hb = {signB & opB[17], opB[17:9]};
  assign full = fa * fb;
  assign lp = la * lb;
  assign hp = ha * hb;
  assign product_next = width9 ? {hp[17:0], lp[17:0]} : full[35:0];

  // Post-multiply pipeline register
  always_ff @(posedge clk or negedge prodRst_n) begin
    if (!prodRst_n) begin
      product <= 36'h0_0000_0000;
    end else if (enable) begin
      product <= product_next;
    end
  end
endmodule : dspma_mult

// *** core/dspma_top.sv ***
`timescale 1ns/1ps
`include "dspma_cfg.svh"
// ==========================================
// Operation
// - Four-product mode adds both first-level results
// - One product width for whole block
// - FIR: data and coefficient shift chains
// - Four taps per block, cascade beyond
// - Simple mode: 8x9, 4x18, 1x36 products
// - Two 52-bit accumulators, not at 36
// - Two-product sums, none at 36 bits
// - Counts hold for matched operand signs
// - Outputs and chains cascade to neighbour
// - Shift chain routed out of block
// - No adders or accumulators at 36
// - Eight units of 18 in, 18 out
// - Ten direct-link inputs from neighbour
// - Nine outputs left, nine right
// - Sign/add controls delayed zero to two stages
// - High add select adds, low subtracts
// - Load strobe replaces accumulator with product
// - Registered, non-sticky accumulator overflow flag
// - Exactly one mode per block
module dspma_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [17:0] operand_word_0,
  input wire logic [17:0] operand_word_1,
  input wire logic [17:0] operand_word_2,
  input wire logic [17:0] operand_word_3,
  input wire logic [17:0] operand_word_4,
  input wire logic [17:0] operand_word_5,
  input wire logic [17:0] operand_word_6,
  input wire logic [17:0] operand_word_7,
  input wire logic [9:0] directLinkIn,
  input wire logic [3:0] clkEnable,
  input wire logic [3:0] asyncClear,
  input wire logic signA,
  input wire logic signB,
  input wire logic add_select_upper,
  input wire logic add_select_lower,
  input wire logic acc_load_0,
  input wire logic acc_load_1,
  input wire logic [17:0] shiftInA,
  input wire logic [17:0] shiftInB,
  output logic [17:0] shiftOutA,
  output logic [17:0] shiftOutB,
  output logic [17:0] result_word_0,
  output logic [17:0] result_word_1,
  output logic [17:0] result_word_2,
  output logic [17:0] result_word_3,
  output logic [17:0] result_word_4,
  output logic [17:0] result_word_5,
  output logic [17:0] result_word_6,
  output logic [17:0] result_word_7,
  output logic [71:0] cascadeOut,
  output logic [71:0] leftLinkOut,
  output logic [71:0] rightLinkOut,
  output logic overflow0,
  output logic overflow1
);
  // ==========================================
  // Declarations
  logic [9:0] cfgReg;
  logic [31:0] rdata_reg;
  logic busWr;
  logic [7:0] busAddr;
  logic [3:0] grpRst_n;
  logic [7:0][17:0] opW;
  logic [`DSPMA_CTL_W-1:0] ctlIn;
  logic [`DSPMA_CTL_W-1:0] ctlS1;
  logic [`DSPMA_CTL_W-1:0] ctlS2;
  logic [`DSPMA_CTL_W-1:0] ctl;
  logic [3:0][17:0] regA;
  logic [3:0][17:0] regB;
  logic [3:0][17:0] aPrev;
  logic [3:0][17:0] bPrev;
  logic [3:0][17:0] mulA;
  logic [3:0][17:0] mulB;
  logic [3:0] mulSa;
  logic [3:0] mulSb;
  logic [3:0][35:0] prod;
  logic [3:0][38:0] fl;
  logic [39:0] sumA;
  logic [39:0] sumB;
  logic [71:0] prod72;
  logic [1:0][51:0] accReg;
  logic [1:0][51:0] macIn;
  logic [1:0][52:0] accSum;
  logic [1:0] ovfNext;
  logic [1:0] ovf_reg;
  logic [143:0] resComb;
  logic [143:0] outReg;
  logic [143:0] resFlat;
  dspma_pkg::dspma_mode_t mode;
  dspma_pkg::dspma_width_t width;
  logic w9;
  logic w36;
  logic illegal;
  logic chainOn;
  logic sx;
  logic addrPhase;

  assign mode = dspma_pkg::dspma_mode_t'(cfgReg[`DSPMA_CFG_MODE]);
  assign width = dspma_pkg::dspma_width_t'(cfgReg[`DSPMA_CFG_WIDTH]);
  assign w9 = (width == dspma_pkg::DSPMA_W9);
  assign w36 = (width == dspma_pkg::DSPMA_W36);
  // no adder stage at 36 bits
  assign illegal = (width == dspma_pkg::DSPMA_WRSV) ||
                   (w36 && (mode != dspma_pkg::DSPMA_SIMPLE));

  // ==========================================
  // AHB-Lite slave, zero wait states
  assign hreadyout = 1'h1;
  assign hresp = `DSPMA_HRESP_OKAY;
  assign hrdata = rdata_reg;
  assign addrPhase = hsel && hready && htrans[1];

  // Address phase capture and read data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busWr <= 1'h0;
      busAddr <= 8'h00;
      rdata_reg <= 32'h0000_0000;
    end else begin
      busWr <= addrPhase && hwrite;
      busAddr <= haddr[7:0];
      if (addrPhase && !hwrite) begin
        case (haddr[7:0])
          `DSPMA_ADDR_CFG: rdata_reg <= {22'h00_0000, cfgReg};
          `DSPMA_ADDR_STAT: rdata_reg <= {29'h0000_0000, illegal, ovf_reg};
          default: rdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfgReg <= `DSPMA_CFG_RST;
    end else if (busWr && (busAddr == `DSPMA_ADDR_CFG)) begin
      cfgReg <= hwdata[9:0];
    end
  end

  // ==========================================
  // Control bus and clears
  // clears bypass clock and enable
  assign grpRst_n = {4{rst_n}} & ~asyncClear;
  // control bus bits from outside rows
  assign ctlIn = {signB, signA, add_select_lower, add_select_upper, acc_load_1, acc_load_0};

  always_ff @(posedge clk or negedge grpRst_n[3]) begin
    if (!grpRst_n[3]) begin
      ctlS1 <= '0;
      ctlS2 <= '0;
    end else if (clkEnable[3]) begin
      ctlS1 <= ctlIn;
      ctlS2 <= ctlS1;
    end
  end

  always_comb begin
    case (cfgReg[`DSPMA_CFG_STAGES])
      2'h0: ctl = ctlIn;
      2'h1: ctl = ctlS1;
      default: ctl = ctlS2;
    endcase
  end
  assign sx = ctl[`DSPMA_CTL_SIGNA] | ctl[`DSPMA_CTL_SIGNB];

  // ==========================================
  // Input registers and shift chains
  // direct-link inputs replace low bits
  assign opW[0] = cfgReg[`DSPMA_CFG_DLINK] ?
                  {operand_word_0[17:10], directLinkIn} : operand_word_0;
  assign opW[7:1] = {operand_word_7, operand_word_6, operand_word_5, operand_word_4,
                     operand_word_3, operand_word_2, operand_word_1};
  assign chainOn = cfgReg[`DSPMA_CFG_CHAIN] && !w36;
  assign aPrev = {regA[2], regA[1], regA[0], shiftInA};
  assign bPrev = {regB[2], regB[1], regB[0], shiftInB};

  always_ff @(posedge clk or negedge grpRst_n[0]) begin
    if (!grpRst_n[0]) begin
      regA <= '0;
      regB <= '0;
    end else if (clkEnable[0]) begin
      for (int k = 0; k < 4; k++) begin
        regA[k] <= chainOn ? aPrev[k] : opW[2*k];
        regB[k] <= (chainOn && !cfgReg[`DSPMA_CFG_COEFPAR]) ? bPrev[k] : opW[2*k+1];
      end
    end
  end
  assign shiftOutA = regA[3];
  assign shiftOutB = regB[3];

  // ==========================================
  // Multipliers, cross-routed for 36x36
  assign mulA = {w36 ? regA[0] : regA[3], w36 ? regA[1] : regA[2], regA[1], regA[0]};
  assign mulB = {w36 ? regB[1] : regB[3], w36 ? regB[0] : regB[2], regB[1], regB[0]};
  assign mulSa = w36 ? {1'h0, ctl[`DSPMA_CTL_SIGNA], ctl[`DSPMA_CTL_SIGNA], 1'h0}
                     : {4{ctl[`DSPMA_CTL_SIGNA]}};
  assign mulSb = w36 ? {ctl[`DSPMA_CTL_SIGNB], 1'h0, ctl[`DSPMA_CTL_SIGNB], 1'h0}
                     : {4{ctl[`DSPMA_CTL_SIGNB]}};

  // One sub-block per operand pair
  for (genvar k = 0; k < 4; k++) begin : gMul
    dspma_mult uMul (
      .clk(clk),
      .prodRst_n(grpRst_n[1]),
      .enable(clkEnable[1]),
      .opA(mulA[k]),
      .opB(mulB[k]),
      .width9(w9),
      .signA(mulSa[k]),
      .signB(mulSb[k]),
      .product(prod[k])
    );
  end

  assign prod72 = {36'h0_0000_0000, prod[0]} + {prod[1], 36'h0_0000_0000} +
                  {{18{ctl[`DSPMA_CTL_SIGNA] & prod[2][35]}}, prod[2], 18'h0_0000} +
                  {{18{ctl[`DSPMA_CTL_SIGNB] & prod[3][35]}}, prod[3], 18'h0_0000};

  // ==========================================
  // First-level adder/subtractors
  always_comb begin
    logic add;
    logic [38:0] x;
    logic [38:0] y;
    add = 1'h0;
    x = '0;
    y = '0;
    fl = '0;
    for (int j = 0; j < 2; j++) begin
      add = (j == 0) ? ctl[`DSPMA_CTL_ADDU] : ctl[`DSPMA_CTL_ADDL];
      if (w9) begin
        x = {{21{sx & prod[2*j][17]}}, prod[2*j][17:0]};
        y = {{21{sx & prod[2*j+1][17]}}, prod[2*j+1][17:0]};
        fl[2*j] = add ? x + y : x - y;
        x = {{21{sx & prod[2*j][35]}}, prod[2*j][35:18]};
        y = {{21{sx & prod[2*j+1][35]}}, prod[2*j+1][35:18]};
        fl[2*j+1] = add ? x + y : x - y;
      end else begin
        x = {{3{sx & prod[2*j][35]}}, prod[2*j]};
        y = {{3{sx & prod[2*j+1][35]}}, prod[2*j+1]};
        fl[2*j] = add ? x + y : x - y;
      end
    end
  end

  assign sumA = {fl[0][38], fl[0]} + {fl[2][38], fl[2]};
  assign sumB = {fl[1][38], fl[1]} + {fl[3][38], fl[3]};

  // ==========================================
  // Accumulators
  always_comb begin
    logic [1:0] ld;
    logic [1:0] ad;
    ld = {ctl[`DSPMA_CTL_LOAD1], ctl[`DSPMA_CTL_LOAD0]};
    ad = {ctl[`DSPMA_CTL_ADDL], ctl[`DSPMA_CTL_ADDU]};
    for (int j = 0; j < 2; j++) begin
      macIn[j] = w9 ? {{34{sx & prod[2*j+1][17]}}, prod[2*j+1][17:0]}
                    : {{16{sx & prod[2*j+1][35]}}, prod[2*j+1]};
      accSum[j] = ad[j] ? {sx & accReg[j][51], accReg[j]} + {sx & macIn[j][51], macIn[j]}
                        : {sx & accReg[j][51], accReg[j]} - {sx & macIn[j][51], macIn[j]};
      ovfNext[j] = ld[j] ? 1'h0 : (sx ? accSum[j][52] ^ accSum[j][51] : accSum[j][52]);
    end
  end

  always_ff @(posedge clk or negedge grpRst_n[2]) begin
    if (!grpRst_n[2]) begin
      accReg <= '0;
    end else if (clkEnable[2] && (mode == dspma_pkg::DSPMA_MAC) && !illegal) begin
      accReg[0] <= ctl[`DSPMA_CTL_LOAD0] ? macIn[0] : accSum[0][51:0];
      accReg[1] <= ctl[`DSPMA_CTL_LOAD1] ? macIn[1] : accSum[1][51:0];
    end
  end

  // overflow follows each step, not held
  always_ff @(posedge clk or negedge grpRst_n[2]) begin
    if (!grpRst_n[2]) begin
      ovf_reg <= 2'h0;
    end else if (clkEnable[2]) begin
      ovf_reg <= ((mode == dspma_pkg::DSPMA_MAC) && !illegal) ? ovfNext : 2'h0;
    end
  end
  assign overflow0 = ovf_reg[0];
  assign overflow1 = ovf_reg[1];

  // ==========================================
  // Output selection
  // one width field for every product
  always_comb begin
    resComb = '0;
    case (mode)
      dspma_pkg::DSPMA_SIMPLE: resComb = w36 ? {72'h0, prod72} : prod;
      dspma_pkg::DSPMA_MAC: resComb = {18'h0_0000, {2{sx & accReg[1][51]}}, accReg[1],
                                       18'h0_0000, {2{sx & accReg[0][51]}}, accReg[0]};
      dspma_pkg::DSPMA_ADD2: resComb = w9 ? {fl[3][35:0], fl[2][35:0], fl[1][35:0], fl[0][35:0]}
                                          : {{33{fl[2][38]}}, fl[2], {33{fl[0][38]}}, fl[0]};
      dspma_pkg::DSPMA_ADD4: resComb = {{32{sumB[39]}}, sumB, {32{sumA[39]}}, sumA};
      default: resComb = '0;
    endcase
    if (illegal) begin
      resComb = '0;
    end
  end

  // Optional output register
  always_ff @(posedge clk or negedge grpRst_n[2]) begin
    if (!grpRst_n[2]) begin
      outReg <= '0;
    end else if (clkEnable[2]) begin
      outReg <= resComb;
    end
  end
  assign resFlat = (cfgReg[`DSPMA_CFG_OUTREG] && (mode != dspma_pkg::DSPMA_MAC)) ?
                   outReg : resComb;

  assign result_word_0 = resFlat[17:0];
  assign result_word_1 = resFlat[35:18];
  assign result_word_2 = resFlat[53:36];
  assign result_word_3 = resFlat[71:54];
  assign result_word_4 = resFlat[89:72];
  assign result_word_5 = resFlat[107:90];
  assign result_word_6 = resFlat[125:108];
  assign result_word_7 = resFlat[143:126];
  // lower half passed down the column
  assign cascadeOut = resFlat[71:0];

  // nine bits each side per unit
  for (genvar u = 0; u < 8; u++) begin : gLink
    assign leftLinkOut[u*9 +: 9] = resFlat[u*18 +: 9];
    assign rightLinkOut[u*9 +: 9] = resFlat[u*18+9 +: 9];
  end

  // ==========================================
  // Assertions
  property p_load;
    @(posedge clk) disable iff (!rst_n || asyncClear[2])
    (clkEnable[2] && !asyncClear[2] && mode == dspma_pkg::DSPMA_MAC && !illegal &&
     ctl[`DSPMA_CTL_LOAD0]) |=> (accReg[0] == $past(macIn[0])) && !ovf_reg[0];
  endproperty
  a_load: assert property (p_load) else $error("load did not replace accumulator");

  property p_acc;
    @(posedge clk) disable iff (!rst_n || asyncClear[2])
    (clkEnable[2] && !asyncClear[2] && mode == dspma_pkg::DSPMA_MAC && !illegal &&
     !ctl[`DSPMA_CTL_LOAD1]) |=> accReg[1] == $past(accSum[1][51:0]);
  endproperty
  a_acc: assert property (p_acc) else $error("accumulator did not step");

  property p_ovf;
    @(posedge clk) disable iff (!rst_n || asyncClear[2])
    (clkEnable[2] && !asyncClear[2] && mode != dspma_pkg::DSPMA_MAC) |=> ovf_reg == 2'h0;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow outside accumulate");

  property p_illegal;
    @(posedge clk) disable iff (!rst_n)
    (w36 && mode != dspma_pkg::DSPMA_SIMPLE) |-> resComb == '0;
  endproperty
  a_illegal: assert property (p_illegal) else $error("adder used at 36 bits");

  property p_add;
    @(posedge clk) disable iff (!rst_n)
    (!w9 && ctl[`DSPMA_CTL_ADDU]) |-> fl[0] == {{3{sx & prod[0][35]}}, prod[0]} +
                                              {{3{sx & prod[1][35]}}, prod[1]};
  endproperty
  a_add: assert property (p_add) else $error("upper stage did not add");

  property p_sub;
    @(posedge clk) disable iff (!rst_n)
    (!w9 && !ctl[`DSPMA_CTL_ADDL]) |-> fl[2] == {{3{sx & prod[2][35]}}, prod[2]} -
                                               {{3{sx & prod[3][35]}}, prod[3]};
  endproperty
  a_sub: assert property (p_sub) else $error("lower stage did not subtract");

  property p_four;
    @(posedge clk) disable iff (!rst_n)
    (mode == dspma_pkg::DSPMA_ADD4 && !illegal) |->
      resComb[39:0] == ({fl[0][38], fl[0]} + {fl[2][38], fl[2]});
  endproperty
  a_four: assert property (p_four) else $error("four-product sum wrong");

  property p_simple;
    @(posedge clk) disable iff (!rst_n)
    (mode == dspma_pkg::DSPMA_SIMPLE && width == dspma_pkg::DSPMA_W18) |-> resComb == prod;
  endproperty
  a_simple: assert property (p_simple) else $error("simple products wrong");

  property p_stage2;
    @(posedge clk) disable iff (!rst_n)
    (cfgReg[`DSPMA_CFG_STAGES] == 2'h2 && clkEnable[3] && !asyncClear[3]) ##1
    (cfgReg[`DSPMA_CFG_STAGES] == 2'h2 && clkEnable[3] && !asyncClear[3]) |=>
      ctl == $past(ctlIn, 2);
  endproperty
  a_stage2: assert property (p_stage2) else $error("control latency not two");

  property p_chain;
    @(posedge clk) disable iff (!rst_n)
    (chainOn && clkEnable[0] && !asyncClear[0]) |=>
      regA[1] == $past(regA[0]) && regA[0] == $past(shiftInA);
  endproperty
  a_chain: assert property (p_chain) else $error("data chain did not shift");

  c_four: cover property (@(posedge clk) disable iff (!rst_n)
    mode == dspma_pkg::DSPMA_ADD4 && chainOn && clkEnable[0]);
  c_ovf: cover property (@(posedge clk) disable iff (!rst_n) ovf_reg[0]);
  c_load: cover property (@(posedge clk) disable iff (!rst_n)
    mode == dspma_pkg::DSPMA_MAC && ctl[`DSPMA_CTL_LOAD1]);
  c_wide: cover property (@(posedge clk) disable iff (!rst_n)
    mode == dspma_pkg::DSPMA_SIMPLE && w36);
endmodule : dspma_top

// *** testbench/dspma_rows.sv ***
`timescale 1ns/1ps
// ==========================================
// Logic rows beside the block: control fan-out, overflow capture
module dspma_rows (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [17:0] ctrlBus,
  input wire logic overflow0,
  input wire logic overflow1,
  output logic signA,
  output logic signB,
  output logic addU,
  output logic addL,
  output logic load0,
  output logic load1,
  output logic [3:0] en,
  output logic [3:0] clr,
  output logic [1:0] stickyOvf
);
  // row order
  // Bus bits by source row; row clocks 4,7,10,13 fold into clk
  assign signA = ctrlBus[0];
  assign clr = {ctrlBus[15], ctrlBus[9], ctrlBus[6], ctrlBus[1]};
  assign load0 = ctrlBus[2];
  assign addU = ctrlBus[3];
  assign en = {ctrlBus[14], ctrlBus[11], ctrlBus[8], ctrlBus[5]};
  assign signB = ctrlBus[12];
  assign load1 = ctrlBus[16];
  assign addL = ctrlBus[17];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stickyOvf <= 2'h0;
    end else begin
      stickyOvf <= stickyOvf | {overflow1, overflow0};
    end
  end
endmodule : dspma_rows

// *** testbench/dsp_multiply_add_block_test.sv ***
`timescale 1ns/1ps
// ==========================================
// Self-checking bench for the multiply-add block
module dsp_multiply_add_block_test;
  typedef struct packed {
    logic [9:0] cfg;
    logic [17:0] ctl;
    logic [71:0] lo;
    logic [71:0] hi;
  } dspma_row_t;
  localparam logic [17:0] CTL0 = 18'h2_6DB8;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [143:0] ops = {18'h6, 18'h7, 18'h8, 18'h9, 18'h2, 18'h3, 18'h4, 18'h5};
  logic [17:0] ctrlBus = CTL0;
  logic [17:0] shA = 18'h1234;
  logic [17:0] shB = 18'h0ABC;
  logic hready, hreadyout, hresp, sgA, sgB, adU, adL, ld0, ld1, ov0, ov1;
  logic [31:0] hrdata, rd;
  logic [143:0] res;
  logic [71:0] cas, lft, rgt;
  logic [17:0] soA, soB;
  logic [3:0] en, clr;
  logic [1:0] sticky;
  logic [51:0] acc;
  int mismatches = 0;
  int cmpCount = 0;
  int cycles = 0;
  dspma_row_t tbl [15];

  assign hready = hreadyout;

  // Clock at 50 MHz
  initial begin
    forever #10 clk = ~clk;
  end

  // Control rows model
  dspma_rows partner (.clk(clk), .rst_n(rst_n), .ctrlBus(ctrlBus), .overflow0(ov0),
    .overflow1(ov1), .signA(sgA), .signB(sgB), .addU(adU), .addL(adL), .load0(ld0),
    .load1(ld1), .en(en), .clr(clr), .stickyOvf(sticky));

  // Design under test
  dspma_top uut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .operand_word_0(ops[17:0]), .operand_word_1(ops[35:18]),
    .operand_word_2(ops[53:36]), .operand_word_3(ops[71:54]), .operand_word_4(ops[89:72]),
    .operand_word_5(ops[107:90]), .operand_word_6(ops[125:108]),
    .operand_word_7(ops[143:126]), .directLinkIn(10'h007), .clkEnable(en), .asyncClear(clr),
    .signA(sgA), .signB(sgB), .add_select_upper(adU), .add_select_lower(adL),
    .acc_load_0(ld0), .acc_load_1(ld1), .shiftInA(shA), .shiftInB(shB), .shiftOutA(soA),
    .shiftOutB(soB), .result_word_0(res[17:0]), .result_word_1(res[35:18]),
    .result_word_2(res[53:36]), .result_word_3(res[71:54]), .result_word_4(res[89:72]),
    .result_word_5(res[107:90]), .result_word_6(res[125:108]),
    .result_word_7(res[143:126]), .cascadeOut(cas), .leftLinkOut(lft), .rightLinkOut(rgt),
    .overflow0(ov0), .overflow1(ov1));

  // Verdict and end of run
  task automatic summarize();
    if (mismatches == 0 && cmpCount > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize

  // Compare and count
  task automatic chk(input logic [71:0] got, input logic [71:0] exp);
    cmpCount++;
    if (got !== exp) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      mismatches++;
    end
  endtask : chk

  // One single AHB-Lite transfer, read data left in rd
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    hsel <= 1'b0;
  endtask : bus

  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      summarize();
    end
  end

  // Main sequence
  initial begin
    tbl = '{
      '{10'h014, CTL0, (72'h6 << 36) + 72'h14, (72'h2A << 36) + 72'h48},
      '{10'h010, CTL0, (72'h6 << 36) + 72'h14, (72'h2A << 36) + 72'h48},
      '{10'h018, CTL0, (72'h6 << 36) + (72'h16 << 18) + 72'h14, 72'h0},
      '{10'h016, CTL0, 72'h1A, 72'h72},
      '{10'h016, 18'h0_6DB0, 72'hE, 72'h1E},
      '{10'h012, CTL0, 72'h1A, 72'h72},
      '{10'h017, CTL0, 72'h8C, 72'h0},
      '{10'h017, 18'h2_6DB0, 72'h80, 72'h0},
      '{10'h013, CTL0, 72'h8C, 72'h0},
      '{10'h214, CTL0, (72'h6 << 36) + 72'h1C, (72'h2A << 36) + 72'h48},
      '{10'h01A, CTL0, 72'h0, 72'h0},
      '{10'h01C, CTL0, 72'h0, 72'h0},
      '{10'h006, CTL0, 72'h1A, 72'h72},
      '{10'h026, 18'h0_6DB0, 72'hE, 72'h1E},
      '{10'h056, CTL0, 72'h1A, 72'h72}};
    repeat (12) @(posedge clk);
    chk(res[71:0], 72'h0);
    chk(res[143:72], 72'h0);
    chk({70'h0, hreadyout, hresp}, 72'h2);
    rst_n <= 1'b1;
    bus(1'b0, 32'h0000_0000, 32'h0000_0000);
    chk({40'h0, rd}, 72'h0);
    // Table of modes and widths
    foreach (tbl[i]) begin
      bus(1'b1, 32'h0000_0000, {22'h0, tbl[i].cfg});
      @(posedge clk);
      ctrlBus <= tbl[i].ctl;
      repeat (4) @(posedge clk);
      #1;
      chk(res[71:0], tbl[i].lo);
      chk(res[143:72], tbl[i].hi);
      chk(cas, tbl[i].lo);
      chk({63'h0, lft[8:0]}, {63'h0, tbl[i].lo[8:0]});
      chk({63'h0, rgt[8:0]}, {63'h0, tbl[i].lo[17:9]});
    end
    // Accumulators: load, subtract past zero, add, clear
    bus(1'b1, 32'h0000_0000, 32'h0000_0015);
    @(posedge clk);
    ctrlBus <= CTL0 | 18'h1_0004;
    repeat (4) @(posedge clk);
    #1;
    chk({18'h0, res[53:0]}, 72'h6);
    chk({18'h0, res[125:72]}, 72'h2A);
    @(posedge clk);
    ctrlBus <= 18'h2_6DB0;
    repeat (6) @(posedge clk);
    #1;
    chk({71'h0, sticky[0]}, 72'h1);
    chk({71'h0, ov0}, 72'h0);
    chk({71'h0, ov1}, 72'h0);
    acc = res[51:0];
    @(posedge clk);
    #1;
    chk({20'h0, res[51:0]}, {20'h0, acc - 52'h6});
    @(posedge clk);
    ctrlBus <= CTL0;
    repeat (4) @(posedge clk);
    #1;
    acc = res[51:0];
    @(posedge clk);
    #1;
    chk({20'h0, res[51:0]}, {20'h0, acc + 52'h6});
    @(posedge clk);
    ctrlBus <= CTL0 | 18'h0_0200;
    #2;
    chk({20'h0, res[51:0]}, 72'h0);
    @(posedge clk);
    ctrlBus <= CTL0;
    // Shift chains, four stages end to end
    bus(1'b1, 32'h0000_0000, 32'h0000_0094);
    repeat (6) @(posedge clk);
    shA <= 18'h0055;
    repeat (3) @(posedge clk);
    #1;
    chk({54'h0, soA}, 72'h1234);
    @(posedge clk);
    #1;
    chk({54'h0, soA}, 72'h55);
    chk({54'h0, soB}, 72'h0ABC);
    // Coefficients loaded in parallel
    bus(1'b1, 32'h0000_0000, 32'h0000_0194);
    repeat (2) @(posedge clk);
    #1;
    chk({54'h0, soB}, 72'h6);
    // Register readback, illegal flag, unmapped place
    bus(1'b1, 32'h0000_0000, 32'hFFFF_FFFF);
    bus(1'b0, 32'h0000_0000, 32'h0000_0000);
    chk({40'h0, rd}, 72'h3FF);
    bus(1'b0, 32'h0000_0004, 32'h0000_0000);
    chk({71'h0, rd[2]}, 72'h1);
    bus(1'b0, 32'h0000_0008, 32'h0000_0000);
    chk({40'h0, rd}, 72'h0);
    summarize();
  end
endmodule : dsp_multiply_add_block_test
